/* File: include/cbr_pkg.sv */
// cbr_pkg: constants and carrier types for the configurable block RAM
// assumes one clock shared by the register bus and both user ports

package cbr_pkg;

   // ------------------------------------------------------------
   // array geometry
   // ------------------------------------------------------------
   localparam int ROWS = 512;
   localparam int ROW_AW = 9;
   localparam int ROW_W = 18;
   localparam int PORT_AW = 13;
   localparam int PORT_DW = 18;
   localparam int FILL_W = 14;
   localparam logic [FILL_W-1:0] CAP_NARROW = 14'h2000;
   localparam logic [FILL_W-1:0] CAP_WIDE = 14'h2400;

   // ------------------------------------------------------------
   // register map (byte offsets)
   // ------------------------------------------------------------
   localparam int REG_AW = 8;
   localparam logic [REG_AW-1:0] REG_CTRL = 8'h00;
   localparam logic [REG_AW-1:0] REG_STATUS = 8'h04;
   localparam logic [REG_AW-1:0] REG_FIFO_FILL = 8'h08;
   localparam logic [REG_AW-1:0] REG_INIT_ADDR = 8'h0C;
   localparam logic [REG_AW-1:0] REG_INIT_DATA = 8'h10;

   // control fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_WA_LSB = 4;
   localparam int CTRL_WB_LSB = 8;
   localparam int CTRL_OREG_A_BIT = 12;
   localparam int CTRL_OREG_B_BIT = 13;
   localparam int CTRL_RUN_BIT = 16;
   localparam int CTRL_FILL_BIT = 17;
   localparam logic [31:0] CTRL_WMASK = 32'h0001_3777;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;

   // status fields
   localparam int ST_FULL_BIT = 0;
   localparam int ST_EMPTY_BIT = 1;
   localparam int ST_RUN_BIT = 2;
   localparam int ST_BUSY_BIT = 3;
   localparam int ST_CFG_ERR_BIT = 4;

   // reset values
   localparam logic [ROW_W-1:0] PATTERN_RST = 18'h00000;
   localparam logic [ROW_AW-1:0] INIT_ROW_RST = 9'h000;
   localparam logic [FILL_W-1:0] FILL_RST = 14'h0000;
   localparam logic HRESP_OKAY = 1'b0;

   // ------------------------------------------------------------
   // modes and port widths
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      CBR_SP,
      CBR_TDP,
      CBR_PDP,
      CBR_FIFO,
      CBR_ROM
   } cbr_mode_e;
   localparam logic [2:0] MODE_LAST = 3'h4;

   localparam logic [2:0] W_1 = 3'h0;
   localparam logic [2:0] W_2 = 3'h1;
   localparam logic [2:0] W_4 = 3'h2;
   localparam logic [2:0] W_9 = 3'h3;
   localparam logic [2:0] W_18 = 3'h4;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic en;
      logic we;
      logic [PORT_AW-1:0] addr;
      logic [PORT_DW-1:0] wdata;
   } cbr_port_req_s;

   typedef struct packed {
      logic en;
      logic we;
      logic [ROW_AW-1:0] row;
      logic [ROW_W-1:0] wdata;
      logic [ROW_W-1:0] wmask;
   } cbr_row_req_s;

endpackage

/* File: design/cbr_mem.sv */
// cbr_mem: two-port storage array with bit write masks
// assumes requests arrive already aligned to rows on the shared clock

module cbr_mem
   import cbr_pkg::*;
#(
   parameter int DEPTH = ROWS
) (
   // clock and reset
   input logic clk,
   input logic reset_n,
   // row requests
   input cbr_row_req_s req0,
   input cbr_row_req_s req1,
   // read data
   output logic [ROW_W-1:0] rdata0,
   output logic [ROW_W-1:0] rdata1
);

   logic [ROW_W-1:0] mem [DEPTH];

   // both ports write in one process; port 1 wins on a shared bit
   always_ff @(posedge clk) begin
      for (int b = 0; b < ROW_W; b++) begin
         if (req0.en && req0.we && req0.wmask[b]) begin
            mem[req0.row][b] <= req0.wdata[b];
         end
         if (req1.en && req1.we && req1.wmask[b]) begin
            mem[req1.row][b] <= req1.wdata[b];
         end
      end
   end

   // read before write: a read sees the row as it was
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata0 <= '0;
         rdata1 <= '0;
      end else begin
         if (req0.en && !req0.we) begin
            rdata0 <= mem[req0.row];
         end
         if (req1.en && !req1.we) begin
            rdata1 <= mem[req1.row];
         end
      end
   end

endmodule

/* File: design/cbr_top.sv */
// cbr_top: configurable block RAM with AHB-Lite control registers
// assumes bus, user ports and flags all run on clk
//
// What this block does
// - mode field chooses RAM, ROM or FIFO use of the array.
// - FIFO pointers, fill count and flags are built into the block.
// - single and true dual port offer 8192x1, 4096x2, 2048x4, 1024x9.
// - pseudo dual port and FIFO also offer 512x18.
// - each port has its own width field in multi-port modes.
// - bits run LSB to MSB of word 0, then word 1, on every port.
// - contents may be preloaded while the block is not running.
// - a fill command writes one shared pattern, all-zero by default.
// - write data and addresses are captured at the array input edge.
// - optional output register delays read data by one clock.

module cbr_top
   import cbr_pkg::*;
(
   // clock and reset
   input logic clk,
   input logic reset_n,
   // ahb-lite register slave
   input logic hsel,
   input logic [31:0] haddr,
   input logic [1:0] htrans,
   input logic hwrite,
   input logic [2:0] hsize,
   input logic [31:0] hwdata,
   input logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // user port a
   input cbr_port_req_s port_a_req,
   output logic [PORT_DW-1:0] port_a_rdata,
   output logic port_a_rvalid,
   // user port b
   input cbr_port_req_s port_b_req,
   output logic [PORT_DW-1:0] port_b_rdata,
   output logic port_b_rvalid,
   // fifo flags
   output logic fifo_full,
   output logic fifo_empty
);

   // ------------------------------------------------------------
   // width helpers
   // ------------------------------------------------------------
   function automatic logic [ROW_AW-1:0] row_of(logic [2:0] w,
         logic [PORT_AW-1:0] a);
      case (w)
         W_1: row_of = a[12:4];
         W_2: row_of = a[11:3];
         W_4: row_of = a[10:2];
         W_9: row_of = a[9:1];
         default: row_of = a[8:0];
      endcase
   endfunction

   function automatic logic [4:0] lane_of(logic [2:0] w,
         logic [PORT_AW-1:0] a);
      case (w)
         W_1: lane_of = {1'b0, a[3:0]};
         W_2: lane_of = {1'b0, a[2:0], 1'b0};
         W_4: lane_of = {1'b0, a[1:0], 2'b00};
         W_9: lane_of = a[0] ? 5'h09 : 5'h00;
         default: lane_of = 5'h00;
      endcase
   endfunction

   function automatic logic [4:0] bits_of(logic [2:0] w);
      case (w)
         W_1: bits_of = 5'h01;
         W_2: bits_of = 5'h02;
         W_4: bits_of = 5'h04;
         W_9: bits_of = 5'h09;
         default: bits_of = 5'h12;
      endcase
   endfunction

   function automatic logic [ROW_W-1:0] mask_of(logic [2:0] w);
      case (w)
         W_1: mask_of = 18'h00001;
         W_2: mask_of = 18'h00003;
         W_4: mask_of = 18'h0000F;
         W_9: mask_of = 18'h001FF;
         default: mask_of = 18'h3FFFF;
      endcase
   endfunction

   function automatic logic [PORT_AW-1:0] last_of(logic [2:0] w);
      case (w)
         W_1: last_of = 13'h1FFF;
         W_2: last_of = 13'h0FFF;
         W_4: last_of = 13'h07FF;
         W_9: last_of = 13'h03FF;
         default: last_of = 13'h01FF;
      endcase
   endfunction

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic [31:0] ctrl_q;
   logic [REG_AW-1:0] adr_q;
   logic wr_q;
   logic rdw_q;
   logic [31:0] hrdata_q;
   logic busy_q;
   logic [ROW_AW-1:0] fill_row_q;
   logic [ROW_AW-1:0] init_row_q;
   logic [ROW_W-1:0] pattern_q;
   logic [PORT_AW-1:0] wptr_q;
   logic [PORT_AW-1:0] rptr_q;
   logic [FILL_W-1:0] fill_q;
   logic [FILL_W-1:0] fill_d;

   logic acc;
   logic wen_ctrl;
   logic wen_iaddr;
   logic init_wr;
   logic fill_go;
   logic [2:0] mode_raw;
   logic [2:0] wa;
   logic [2:0] wb;
   cbr_mode_e mode;
   logic run;
   logic cfg_err;
   logic live;
   logic wide_a;
   logic wide_b;
   logic push;
   logic pop;
   logic [FILL_W-1:0] cap;
   logic [PORT_AW-1:0] a_addr;
   logic [PORT_AW-1:0] b_addr;
   logic a_wr_ok;
   logic a_rd_ok;
   logic b_wr_ok;
   logic b_rd_ok;
   logic [31:0] rd_mux;
   logic [31:0] status;

   cbr_row_req_s m0;
   cbr_row_req_s m1;
   logic [ROW_W-1:0] m_rdata [2];
   logic rd_go [2];
   logic [2:0] wsel [2];
   logic [4:0] lane_now [2];
   logic oreg [2];
   logic [ROW_W-1:0] rdata [2];
   logic rvalid [2];

   // ------------------------------------------------------------
   // configuration decode
   // ------------------------------------------------------------
   assign mode_raw = ctrl_q[CTRL_MODE_LSB +: 3];
   assign wa = ctrl_q[CTRL_WA_LSB +: 3];
   assign wb = ctrl_q[CTRL_WB_LSB +: 3];
   assign mode = cbr_mode_e'(mode_raw);
   assign run = ctrl_q[CTRL_RUN_BIT];
   assign oreg[0] = ctrl_q[CTRL_OREG_A_BIT];
   assign oreg[1] = ctrl_q[CTRL_OREG_B_BIT];
   assign wide_a = (wa == W_9) || (wa == W_18);
   assign wide_b = (wb == W_9) || (wb == W_18);

   // 18 wide only where two ports split the array; the fifo cannot
   // count a 9-bit side against a 16-bit lane side, so that mix is out
   assign cfg_err = (mode_raw > MODE_LAST)
      || (wa > W_18) || (wb > W_18)
      || ((mode == CBR_SP) && (wa == W_18))
      || (((mode == CBR_TDP) || (mode == CBR_ROM))
          && ((wa == W_18) || (wb == W_18)))
      || ((mode == CBR_FIFO) && (wide_a != wide_b));

   assign live = run && !cfg_err && !busy_q;

   // ------------------------------------------------------------
   // port permissions
   // ------------------------------------------------------------
   // rom refuses every user write even if the user drives one
   assign a_wr_ok = live && port_a_req.en && port_a_req.we
      && (mode != CBR_ROM) && (mode != CBR_FIFO);
   assign a_rd_ok = live && port_a_req.en && !port_a_req.we
      && ((mode == CBR_SP) || (mode == CBR_TDP) || (mode == CBR_ROM));
   assign b_wr_ok = live && port_b_req.en && port_b_req.we
      && (mode == CBR_TDP);
   assign b_rd_ok = (live && port_b_req.en && !port_b_req.we
      && ((mode == CBR_TDP) || (mode == CBR_PDP)
          || (mode == CBR_ROM))) || pop;

   assign a_addr = (mode == CBR_FIFO) ? wptr_q : port_a_req.addr;
   assign b_addr = (mode == CBR_FIFO) ? rptr_q : port_b_req.addr;

   // ------------------------------------------------------------
   // fifo pointers and flags
   // ------------------------------------------------------------
   assign cap = wide_a ? CAP_WIDE : CAP_NARROW;
   assign fifo_full = ({1'b0, fill_q} + {10'h000, bits_of(wa)})
      > {1'b0, cap};
   assign fifo_empty = fill_q < {9'h000, bits_of(wb)};
   assign push = live && (mode == CBR_FIFO) && port_a_req.en
      && port_a_req.we && !fifo_full;
   assign pop = live && (mode == CBR_FIFO) && port_b_req.en
      && !fifo_empty;

   // fill is kept in bits so the two sides may differ in width
   assign fill_d = fill_q
      + (push ? {9'h000, bits_of(wa)} : FILL_RST)
      - (pop ? {9'h000, bits_of(wb)} : FILL_RST);

   // leaving run empties the fifo, so a new mode starts clean
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wptr_q <= '0;
         rptr_q <= '0;
         fill_q <= FILL_RST;
      end else if (!run) begin
         wptr_q <= '0;
         rptr_q <= '0;
         fill_q <= FILL_RST;
      end else begin
         fill_q <= fill_d;
         if (push) begin
            wptr_q <= (wptr_q == last_of(wa)) ? '0 : wptr_q + 1'b1;
         end
         if (pop) begin
            rptr_q <= (rptr_q == last_of(wb)) ? '0 : rptr_q + 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // array requests
   // ------------------------------------------------------------
   // while stopped, port 0 belongs to preload and pattern fill
   assign m0.en = live ? (a_wr_ok || a_rd_ok || push)
      : (init_wr || busy_q);
   assign m0.we = live ? (a_wr_ok || push) : 1'b1;
   assign m0.row = live ? row_of(wa, a_addr)
      : (busy_q ? fill_row_q : init_row_q);
   assign m0.wdata = live
      ? ROW_W'((port_a_req.wdata & mask_of(wa)) << lane_of(wa, a_addr))
      : (busy_q ? pattern_q : hwdata[ROW_W-1:0]);
   assign m0.wmask = live ? ROW_W'(mask_of(wa) << lane_of(wa, a_addr))
      : mask_of(W_18);

   assign m1.en = b_wr_ok || b_rd_ok;
   assign m1.we = b_wr_ok;
   assign m1.row = row_of(wb, b_addr);
   assign m1.wdata =
      ROW_W'((port_b_req.wdata & mask_of(wb)) << lane_of(wb, b_addr));
   assign m1.wmask = ROW_W'(mask_of(wb) << lane_of(wb, b_addr));

   // array registers address and data on this edge
   cbr_mem #(
      .DEPTH(ROWS)
   ) u_mem (
      .clk(clk),
      .reset_n(reset_n),
      .req0(m0),
      .req1(m1),
      .rdata0(m_rdata[0]),
      .rdata1(m_rdata[1])
   );

   // ------------------------------------------------------------
   // read alignment and output register
   // ------------------------------------------------------------
   assign rd_go[0] = a_rd_ok;
   assign rd_go[1] = b_rd_ok;
   assign wsel[0] = wa;
   assign wsel[1] = wb;
   assign lane_now[0] = lane_of(wa, a_addr);
   assign lane_now[1] = lane_of(wb, b_addr);

   for (genvar i = 0; i < 2; i++) begin : g_rd
      logic v1_q;
      logic v2_q;
      logic [4:0] lane_q;
      logic [2:0] w_q;
      logic [ROW_W-1:0] dout_q;
      logic [ROW_W-1:0] aligned;

      assign aligned = (m_rdata[i] >> lane_q) & mask_of(w_q);

      always_ff @(posedge clk or negedge reset_n) begin
         if (!reset_n) begin
            v1_q <= 1'b0;
            v2_q <= 1'b0;
            lane_q <= 5'h00;
            w_q <= W_1;
            dout_q <= '0;
         end else begin
            v1_q <= rd_go[i];
            v2_q <= v1_q && oreg[i];
            if (rd_go[i]) begin
               lane_q <= lane_now[i];
               w_q <= wsel[i];
            end
            if (v1_q) begin
               dout_q <= aligned;
            end
         end
      end

      assign rdata[i] = oreg[i] ? dout_q : aligned;
      assign rvalid[i] = oreg[i] ? v2_q : (v1_q && !oreg[i]);
   end

   assign port_a_rdata = rdata[0];
   assign port_b_rdata = rdata[1];
   assign port_a_rvalid = rvalid[0];
   assign port_b_rvalid = rvalid[1];

   // ------------------------------------------------------------
   // ahb-lite slave
   // ------------------------------------------------------------
   // reads take one wait state so a write just before is visible
   assign acc = hsel && htrans[1] && hready;
   assign hreadyout = !rdw_q;
   assign hresp = HRESP_OKAY;
   assign hrdata = hrdata_q;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_q <= 1'b0;
         rdw_q <= 1'b0;
         adr_q <= '0;
         hrdata_q <= '0;
      end else begin
         wr_q <= acc && hwrite;
         rdw_q <= acc && !hwrite;
         if (acc) begin
            adr_q <= haddr[REG_AW-1:0];
         end
         if (rdw_q) begin
            hrdata_q <= rd_mux;
         end
      end
   end

   assign wen_ctrl = wr_q && (adr_q == REG_CTRL);
   assign wen_iaddr = wr_q && (adr_q == REG_INIT_ADDR);
   assign init_wr = wr_q && (adr_q == REG_INIT_DATA)
      && !run && !busy_q;
   assign fill_go = wen_ctrl && hwdata[CTRL_FILL_BIT]
      && !hwdata[CTRL_RUN_BIT] && !busy_q;

   assign status = {27'h0000000, cfg_err, busy_q, live,
      fifo_empty, fifo_full};

   always_comb begin
      if (adr_q == REG_CTRL) begin
         rd_mux = ctrl_q;
      end else if (adr_q == REG_STATUS) begin
         rd_mux = status;
      end else if (adr_q == REG_FIFO_FILL) begin
         rd_mux = {18'h00000, fill_q};
      end else if (adr_q == REG_INIT_ADDR) begin
         rd_mux = {23'h000000, init_row_q};
      end else if (adr_q == REG_INIT_DATA) begin
         rd_mux = {14'h0000, pattern_q};
      end else begin
         rd_mux = 32'h0000_0000;
      end
   end

   // ------------------------------------------------------------
   // control, preload and pattern fill
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_q <= CTRL_RST;
      end else if (wen_ctrl) begin
         ctrl_q <= hwdata & CTRL_WMASK;
      end
   end

   // preload walks rows by itself so a burst of data words suffices
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         init_row_q <= INIT_ROW_RST;
         pattern_q <= PATTERN_RST;
      end else if (wen_iaddr) begin
         init_row_q <= hwdata[ROW_AW-1:0];
      end else if (init_wr) begin
         init_row_q <= init_row_q + 1'b1;
         pattern_q <= hwdata[ROW_W-1:0];
      end
   end

   // one pattern serves every row; with the reset pattern it clears
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         busy_q <= 1'b0;
         fill_row_q <= '0;
      end else if (fill_go) begin
         busy_q <= 1'b1;
         fill_row_q <= '0;
      end else if (busy_q) begin
         fill_row_q <= fill_row_q + 1'b1;
         busy_q <= (fill_row_q != ROW_AW'(ROWS - 1));
      end
   end

endmodule

/* File: dv/cbr_assertions.sv */
// cbr_assertions: port-level checks for cbr_top
// assumes one clock and an active-low asynchronous reset
module cbr_assertions
   import cbr_pkg::*;
(
   // clock and reset
   input logic clk,
   input logic reset_n,
   // register bus
   input logic hsel,
   input logic [1:0] htrans,
   input logic hwrite,
   input logic hready,
   input logic hreadyout,
   input logic hresp,
   input logic [31:0] hrdata,
   // user ports
   input cbr_port_req_s port_a_req,
   input logic [PORT_DW-1:0] port_a_rdata,
   input logic port_a_rvalid,
   input cbr_port_req_s port_b_req,
   input logic port_b_rvalid,
   // flags
   input logic fifo_full,
   input logic fifo_empty
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   wire take = hsel && htrans[1] && hready;

   read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read did not take exactly one wait state");
   write_nowait_a: assert property (take && hwrite |=> hreadyout)
      else $error("write stalled the bus");
   wait_once_a: assert property (!hreadyout |=> hreadyout)
      else $error("wait state longer than one cycle");
   okay_resp_a: assert property (hresp == HRESP_OKAY)
      else $error("response other than okay");
   hrdata_hold_a: assert property
      (!$stable(hrdata) |-> hreadyout && !$past(hreadyout))
      else $error("read data moved outside a read completion");
   a_rvalid_cause_a: assert property (
      port_a_rvalid |-> $past(port_a_req.en) || $past(port_a_req.en, 2))
      else $error("port a valid without a request");
   b_rvalid_cause_a: assert property (
      port_b_rvalid |-> $past(port_b_req.en) || $past(port_b_req.en, 2))
      else $error("port b valid without a request");
   a_rdata_hold_a: assert property (
      !port_a_rvalid |-> $stable(port_a_rdata))
      else $error("port a data moved without valid");
   flags_apart_a: assert property (!(fifo_full && fifo_empty))
      else $error("fifo full and empty together");
endmodule

bind cbr_top cbr_assertions i_cbr_assertions (
   .clk, .reset_n, .hsel, .htrans, .hwrite, .hready, .hreadyout,
   .hresp, .hrdata, .port_a_req, .port_a_rdata, .port_a_rvalid,
   .port_b_req, .port_b_rvalid, .fifo_full, .fifo_empty
);

/* File: dv/cbr_fabric_model.sv */
// cbr_fabric_model: fabric user logic on both user ports
// assumes clk is shared with cbr_top; latency comes from the caller
module cbr_fabric_model
   import cbr_pkg::*;
(
   // clock
   input logic clk,
   // requests
   output cbr_port_req_s port_a_req,
   output cbr_port_req_s port_b_req,
   // answers
   input logic [PORT_DW-1:0] port_a_rdata,
   input logic port_a_rvalid,
   input logic [PORT_DW-1:0] port_b_rdata,
   input logic port_b_rvalid
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      port_a_req = '0;
      port_b_req = '0;
   end

   task automatic put(input bit b, input cbr_port_req_s r);
      if (b) port_b_req <= r;
      else port_a_req <= r;
   endtask

   // idle lines show the inverse of the last value, so a design that
   // samples them without en sees garbage rather than a stale request
   task automatic rel(input bit b);
      cbr_port_req_s r;
      r = b ? port_b_req : port_a_req;
      r.en = 1'h0;
      r.we = ~r.we;
      r.addr = ~r.addr;
      r.wdata = ~r.wdata;
      put(b, r);
      @(posedge clk);
   endtask

   // lat 0 leaves a write standing for back-to-back use
   task automatic acc(input bit b, input logic we, input int a,
         input int d, input int lat, output logic v, output logic [17:0] q);
      put(b, {1'h1, we, 13'(a), 18'(d)});
      @(posedge clk);
      v = 1'h0;
      q = '0;
      if (lat > 0) begin
         rel(b);
         repeat (lat - 1) @(posedge clk);
         v = b ? port_b_rvalid : port_a_rvalid;
         q = b ? port_b_rdata : port_a_rdata;
      end
   endtask
endmodule

/* File: dv/cbr_top_tb_top.sv */
// cbr_top_tb_top: directed bench for the configurable block RAM
// assumes cbr_top, its checker bind and the fabric model are compiled
module cbr_top_tb_top
   import cbr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'h0;
   logic reset_n = 1'h0;
   logic hsel = 1'h0;
   logic [31:0] haddr = '0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'h0;
   logic [31:0] hwdata = '0;
   logic hreadyout, hresp, v;
   logic [31:0] hrdata, rd;
   cbr_port_req_s port_a_req, port_b_req;
   logic [PORT_DW-1:0] port_a_rdata, port_b_rdata;
   logic [17:0] q;
   logic port_a_rvalid, port_b_rvalid, fifo_full, fifo_empty;
   int fails = 0;
   int samples_checked = 0;
   int cycles = 0;

   always #4 clk = ~clk;

   cbr_top i_cbr_top (.clk, .reset_n, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
      .hrdata, .port_a_req, .port_a_rdata, .port_a_rvalid, .port_b_req,
      .port_b_rdata, .port_b_rvalid, .fifo_full, .fifo_empty);
   cbr_fabric_model i_cbr_fabric_model (.clk, .port_a_req, .port_b_req,
      .port_a_rdata, .port_a_rvalid, .port_b_rdata, .port_b_rvalid);

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic give_verdict;
      if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails++;
         give_verdict();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic ahb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      hsel <= 1'h1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge clk);
      while (hreadyout !== 1'h1) @(posedge clk);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hreadyout !== 1'h1) @(posedge clk);
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      ahb(1'h1, a, d);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      ahb(1'h0, a, '0);
      chk(rd, e);
   endtask

   task automatic pw(input bit b, input int a, input int d);
      i_cbr_fabric_model.acc(b, 1'h1, a, d, 0, v, q);
   endtask

   // bit 18 of e set means a valid answer with data e[17:0]
   task automatic prc(input bit b, input int a, input int lat,
         input logic [18:0] e);
      i_cbr_fabric_model.acc(b, 1'h0, a, 0, lat, v, q);
      if (e[18]) chk({v, q}, e);
      else chk(v, 1'h0);
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_regs;
      rdc(REG_CTRL, CTRL_RST);
      rdc(REG_STATUS, 32'h0000_0002);
      rdc(REG_FIFO_FILL, 32'h0);
      wr(8'h14, 32'hFFFF_FFFF);
      rdc(8'h14, 32'h0);
      // 18 wide on a single port is refused: cfg_err, ports idle
      wr(REG_CTRL, 32'h0000_0040);
      rdc(REG_STATUS, 32'h0000_0012);
   endtask

   task automatic t_rom;
      wr(REG_INIT_ADDR, 32'h0);
      wr(REG_INIT_DATA, 32'h0002_AAAB);
      wr(REG_CTRL, 32'h0001_0334);
      // read only: contents come from the preload, writes stay off
      prc(1'h0, 0, 1, 19'h4_00AB);
      prc(1'h1, 1, 1, 19'h4_0155);
      // a stray user write must leave the preloaded word untouched
      pw(1'h0, 0, 'h1FF);
      prc(1'h0, 0, 1, 19'h4_00AB);
   endtask

   task automatic t_sp;
      wr(REG_CTRL, 32'h0001_0000);
      pw(1'h0, 'h1FFF, 1);
      pw(1'h0, 'h1FFE, 0);
      prc(1'h0, 'h1FFF, 1, 19'h4_0001);
      prc(1'h0, 'h1FFE, 1, 19'h4_0000);
      wr(REG_CTRL, 32'h0001_1000);
      prc(1'h0, 'h1FFF, 1, 19'h0);
      prc(1'h0, 'h1FFF, 2, 19'h4_0001);
   endtask

   task automatic t_tdp;
      wr(REG_CTRL, 32'h0001_0021);
      pw(1'h0, 1, 'hA);
      i_cbr_fabric_model.rel(1'h0);
      for (int k = 0; k < 4; k++)
         prc(1'h1, 4 + k, 1, {1'h1, 17'h0, k[0]});
      // row 0 keeps the preload in bits 11:9, port b sets bit 8
      pw(1'h1, 8, 1);
      prc(1'h0, 2, 1, 19'h4_000B);
      i_cbr_fabric_model.rel(1'h1);
   endtask

   task automatic t_pdp;
      wr(REG_CTRL, 32'h0001_0442);
      pw(1'h0, 3, 'h3_1234);
      pw(1'h1, 3, 1);
      prc(1'h1, 3, 1, 19'h7_1234);
      prc(1'h0, 3, 1, 19'h0);
   endtask

   task automatic t_fifo;
      wr(REG_CTRL, 32'h0);
      wr(REG_CTRL, 32'h0001_0333);
      chk(fifo_empty, 1'h1);
      for (int k = 0; k < 1024; k++)
         pw(1'h0, 0, (k * 5 + 3) & 'h1FF);
      pw(1'h0, 0, 'h1AA);
      i_cbr_fabric_model.rel(1'h0);
      chk(fifo_full, 1'h1);
      rdc(REG_FIFO_FILL, 32'h2400);
      for (int k = 0; k < 1024; k++)
         prc(1'h1, 0, 1, {1'h1, 18'((k * 5 + 3) & 'h1FF)});
      prc(1'h1, 0, 1, 19'h0);
      chk(fifo_empty, 1'h1);
   endtask

   task automatic t_fill;
      int n;
      n = 0;
      wr(REG_CTRL, 32'h0);
      wr(REG_INIT_DATA, 32'h0);
      wr(REG_CTRL, 32'h0002_0000);
      rdc(REG_STATUS, 32'h0000_000A);
      do ahb(1'h0, REG_STATUS, '0);
      while (rd[ST_BUSY_BIT] === 1'h1 && n++ < 300);
      chk(rd[ST_BUSY_BIT], 1'h0);
      wr(REG_CTRL, 32'h0001_0442);
      prc(1'h1, 3, 1, 19'h4_0000);
   endtask

   initial begin
      repeat (5) @(posedge clk);
      reset_n <= 1'h1;
      @(posedge clk);
      t_regs();
      t_rom();
      t_sp();
      t_tdp();
      t_pdp();
      t_fifo();
      t_fill();
      give_verdict();
   end
endmodule
